//--- design/pcl_cfg.svh
`ifndef PCL_CFG_SVH
`define PCL_CFG_SVH

// Data widths: one half-cacheline unit and one aligned 512b request.
`define PCL_HALF_W 256
`define PCL_LINE_W 512

// Address of a buffer in memory, counted in half-cacheline units.
`define PCL_ADDR_W 26
// Buffer length in half-cacheline units.
`define PCL_LEN_W 6
// Line counters; 63 halves starting on an odd half span 32 lines.
`define PCL_CNT_W 6
// Return buffer line address width and depth.
`define PCL_RB_AW 6
`define PCL_RB_LINES 64
// Number of shader stages with a push-constant region.
`define PCL_STAGES 4
`define PCL_STG_W 2

// Field positions: bit 0 of a half address selects the half in a line.
`define PCL_HALF_BIT 0
`define PCL_LINE_LSB 1

// Reset values.
`define PCL_RST_CNT 6'h00
`define PCL_RST_LINE 25'h0000000
`define PCL_RST_DATA 256'h0

`endif

//--- design/pcl_pkg.sv
`include "pcl_cfg.svh"

package pcl_pkg;

  // Loader sequence: fetch lines, then read halves out one by one.
  typedef enum logic [2:0] {
    PCL_IDLE,
    PCL_FETCH,
    PCL_RD,
    PCL_LATCH,
    PCL_OUT
  } pcl_st_t;

  // One constant buffer load: stage, start half address, length.
  typedef struct packed {
    logic [`PCL_STG_W-1:0] stage;
    logic [`PCL_ADDR_W-1:0] addr;
    logic [`PCL_LEN_W-1:0] len;
  } pcl_cmd_t;

  // Per-stage region base, in return buffer lines.
  typedef logic [`PCL_STAGES-1:0][`PCL_RB_AW-1:0] pcl_region_t;

  // Whole state of the loader.
  typedef struct packed {
    pcl_st_t st;
    pcl_cmd_t cmd;
    logic [`PCL_CNT_W-1:0] nlines;
    logic [`PCL_CNT_W-1:0] req_cnt;
    logic [`PCL_CNT_W-1:0] rsp_cnt;
    logic [`PCL_ADDR_W-2:0] req_line;
    logic [`PCL_LEN_W-1:0] idx;
    logic sel;
    logic out_valid;
    logic [`PCL_HALF_W-1:0] out_data;
  } pcl_state_t;

endpackage

//--- design/pcl_rb_mem.sv
`timescale 1ns/1ps
`include "pcl_cfg.svh"

// Return buffer storage: one line write port, one registered line read.
module pcl_rb_mem
  import pcl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [`PCL_RB_AW-1:0] waddr,
  input wire logic [`PCL_LINE_W-1:0] wdata,
  input wire logic [`PCL_RB_AW-1:0] raddr,
  output logic [`PCL_LINE_W-1:0] rdata
);

  logic [`PCL_LINE_W-1:0] mem [`PCL_RB_LINES];

  // Storage has no reset; software owns what lives in it.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read data is registered, so it is valid one cycle after raddr.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

//--- design/pcl_loader.sv
`timescale 1ns/1ps
`include "pcl_cfg.svh"

// Behaviour
// R1: Each stage's constants live in its own return buffer region.
// R2: Software keeps regions low in the buffer and never overlapping.
// R3: Odd-half start with even length leaves gaps at start and end.
// R4: Odd-half start with odd length leaves a gap only at start.
// R5: Line-aligned start with odd length leaves a gap only at end.
// R6: Copy to thread register space drops gaps, packing halves contiguously.
// R7: Memory reads are aligned 512b requests written to aligned slots.
// R8: Software sizes each region for one buffer plus alignment padding.
// R9: Each half keeps its memory line alignment inside the region.
module pcl_loader
  import pcl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire pcl_cmd_t cmd,
  input wire pcl_region_t region_base,
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output logic [`PCL_ADDR_W-2:0] mem_req_line,
  input wire logic mem_rsp_valid,
  input wire logic [`PCL_LINE_W-1:0] mem_rsp_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [`PCL_HALF_W-1:0] out_data,
  output logic out_last,
  output logic busy
);

  pcl_state_t s;
  pcl_state_t next_s;
  logic rb_we;
  logic [`PCL_RB_AW-1:0] rb_waddr;
  logic [`PCL_RB_AW-1:0] rb_raddr;
  logic [`PCL_LINE_W-1:0] rb_rdata;
  logic [`PCL_ADDR_W:0] end_half;
  logic [`PCL_ADDR_W-2:0] first_line;
  logic [`PCL_ADDR_W-2:0] last_line;
  logic [`PCL_LEN_W:0] half_ofs;
  logic [`PCL_RB_AW-1:0] base;
  logic last_unit;

  ////////////////////////////////////////////////////////////////////////
  // Return buffer storage.

  pcl_rb_mem u_rb (
    .clk(clk),
    .rst(rst),
    .we(rb_we),
    .waddr(rb_waddr),
    .wdata(mem_rsp_data),
    .raddr(rb_raddr),
    .rdata(rb_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address arithmetic.

  // Span of memory lines that a new command touches.
  always_comb begin
    end_half = {1'b0, cmd.addr} + {{(`PCL_ADDR_W-`PCL_LEN_W+1){1'b0}},
               cmd.len} - {{`PCL_ADDR_W{1'b0}}, 1'b1};
    first_line = cmd.addr[`PCL_ADDR_W-1:`PCL_LINE_LSB];
    last_line = end_half[`PCL_ADDR_W-1:`PCL_LINE_LSB];
  end

  // Region base of the active stage, then the packed half being read.
  assign base = region_base[s.cmd.stage]; // [R1]
  // Skipping the leading half of an odd start removes the start gap.
  assign half_ofs = {1'b0, s.idx} +
                    {{`PCL_LEN_W{1'b0}}, s.cmd.addr[`PCL_HALF_BIT]}; // [R6]
  assign last_unit = (s.idx == s.cmd.len - `PCL_LEN_W'(1));

  // Each returned line lands at its line offset from the region base.
  assign rb_we = (s.st == PCL_FETCH) && mem_rsp_valid; // [R7]
  assign rb_waddr = base + s.rsp_cnt; // [R9]
  assign rb_raddr = base + half_ofs[`PCL_LEN_W:1]; // [R6]

  ////////////////////////////////////////////////////////////////////////
  // Handshake outputs.

  assign cmd_ready = (s.st == PCL_IDLE);
  assign mem_req_valid = (s.st == PCL_FETCH) && (s.req_cnt != s.nlines);
  assign mem_req_line = s.req_line;
  assign out_valid = s.out_valid;
  assign out_data = s.out_data;
  assign out_last = s.out_valid && last_unit;
  assign busy = (s.st != PCL_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Next state.

  // The loader fetches whole lines, then streams halves out packed.
  always_comb begin
    next_s = s;
    case (s.st)
      PCL_IDLE: begin
        if (cmd_valid && (cmd.len != '0)) begin
          next_s.cmd = cmd;
          // Whole lines are fetched, so odd ends leave gaps. [R3] [R4] [R5]
          next_s.nlines = `PCL_CNT_W'(last_line - first_line + 1'b1);
          next_s.req_line = first_line; // [R7]
          next_s.req_cnt = `PCL_RST_CNT;
          next_s.rsp_cnt = `PCL_RST_CNT;
          next_s.st = PCL_FETCH;
        end
      end
      PCL_FETCH: begin
        if (mem_req_valid && mem_req_ready) begin
          next_s.req_line = s.req_line + 1'b1; // [R7]
          next_s.req_cnt = s.req_cnt + 1'b1;
        end
        if (mem_rsp_valid) begin
          next_s.rsp_cnt = s.rsp_cnt + 1'b1; // [R9]
          if (s.rsp_cnt + 1'b1 == s.nlines) begin
            next_s.idx = '0;
            next_s.st = PCL_RD;
          end
        end
      end
      PCL_RD: begin
        // Remember which half of the line the unit sits in.
        next_s.sel = half_ofs[`PCL_HALF_BIT]; // [R6]
        next_s.st = PCL_LATCH;
      end
      PCL_LATCH: begin
        next_s.out_data = s.sel ? rb_rdata[`PCL_LINE_W-1:`PCL_HALF_W]
                                : rb_rdata[`PCL_HALF_W-1:0];
        next_s.out_valid = 1'b1;
        next_s.st = PCL_OUT;
      end
      PCL_OUT: begin
        if (out_ready) begin
          next_s.out_valid = 1'b0;
          if (last_unit) begin
            next_s.st = PCL_IDLE;
          end else begin
            next_s.idx = s.idx + 1'b1; // [R6]
            next_s.st = PCL_RD;
          end
        end
      end
      default: begin
        next_s.st = PCL_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.

  // Synchronous reset brings the loader back to idle with nothing out.
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.st <= PCL_IDLE;
      s.req_line <= `PCL_RST_LINE;
      s.out_data <= `PCL_RST_DATA;
    end else begin
      s <= next_s;
    end
  end

endmodule

//--- verification/pcl_loader_assertions.sv
`timescale 1ns/1ps
`include "pcl_cfg.svh"
module pcl_chk
  import pcl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire pcl_cmd_t cmd,
  input wire logic mem_req_valid,
  input wire logic mem_req_ready,
  input wire logic [`PCL_ADDR_W-2:0] mem_req_line,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [`PCL_HALF_W-1:0] out_data,
  input wire logic out_last,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A taken load starts fetching at the line that holds its first half.
  a_fetch_start: assert property (
    cmd_valid && cmd_ready && |cmd.len |=> busy && mem_req_valid
    && mem_req_line == $past(cmd.addr[25:1])) else $error("bad start");
  a_req_hold: assert property (
    mem_req_valid && !mem_req_ready |=> mem_req_valid
    && $stable(mem_req_line)) else $error("request dropped");
  a_req_step: assert property (
    mem_req_valid && mem_req_ready |=> !mem_req_valid
    || mem_req_line == $past(mem_req_line) + 25'h1) else $error("bad line");
  a_out_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data)
    && $stable(out_last)) else $error("half dropped");
  a_out_pace: assert property (
    out_valid && out_ready && !out_last |=> !out_valid [*2] ##1 out_valid)
    else $error("bad pace");
  a_last_end: assert property (
    out_valid && out_ready && out_last |=> cmd_ready && !busy)
    else $error("no idle");
  a_busy_lock: assert property (busy |-> !cmd_ready)
    else $error("ready while busy");
  a_no_mix: assert property (mem_req_valid |-> !out_valid)
    else $error("output during fetch");
endmodule
bind pcl_loader pcl_chk chk (
  .clk(clk),
  .rst(rst),
  .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready),
  .cmd(cmd),
  .mem_req_valid(mem_req_valid),
  .mem_req_ready(mem_req_ready),
  .mem_req_line(mem_req_line),
  .out_valid(out_valid),
  .out_ready(out_ready),
  .out_data(out_data),
  .out_last(out_last),
  .busy(busy)
);

//--- verification/pcl_mem_model.sv
`timescale 1ns/1ps
`include "pcl_cfg.svh"
module pcl_mem_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic mem_req_valid,
  output logic mem_req_ready,
  input wire logic [`PCL_ADDR_W-2:0] mem_req_line,
  output logic mem_rsp_valid,
  output logic [`PCL_LINE_W-1:0] mem_rsp_data
);
  logic [24:0] q[$];
  logic [1:0] t = 2'h0;
  // Content of one half in memory, known from its half address.
  function automatic logic [255:0] hv(input logic [25:0] h);
    return {8{6'h2a, h}};
  endfunction
  initial mem_req_ready = 1'b0;
  initial mem_rsp_valid = 1'b0;
  initial mem_rsp_data = '0;
  // Aligned line reads, answered in order, with stalls when slow.
  always @(posedge clk) begin
    t <= t + 2'h1;
    if (mem_req_valid && mem_req_ready) q.push_back(mem_req_line);
    mem_req_ready <= !slow || t[0];
    if (q.size() > 0 && (!slow || t[1])) begin
      mem_rsp_valid <= 1'b1;
      mem_rsp_data <= {hv({q[0], 1'b1}), hv({q[0], 1'b0})};
      void'(q.pop_front());
    end else begin
      mem_rsp_valid <= 1'b0;
      mem_rsp_data <= ~mem_rsp_data;
    end
  end
endmodule

//--- verification/push_constant_return_buffer_loader_bench.sv
`timescale 1ns/1ps
`include "pcl_cfg.svh"
module push_constant_return_buffer_loader_bench;
  import pcl_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, out_ready = 1'b0;
  logic slow = 1'b0, cmd_ready, mem_req_valid, mem_req_ready;
  logic mem_rsp_valid, out_valid, out_last, busy;
  logic [24:0] mem_req_line;
  logic [511:0] mem_rsp_data;
  logic [255:0] out_data;
  pcl_cmd_t cmd = '0;
  // Low regions that never overlap, each big enough for its load.
  pcl_region_t region_base = {6'h30, 6'h28, 6'h20, 6'h00};
  int mismatches = 0, comparisons = 0, cycles = 0;
  int lines = 0;
  pcl_loader DUT (
    .clk(clk),
    .rst(rst),
    .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready),
    .cmd(cmd),
    .region_base(region_base),
    .mem_req_valid(mem_req_valid),
    .mem_req_ready(mem_req_ready),
    .mem_req_line(mem_req_line),
    .mem_rsp_valid(mem_rsp_valid),
    .mem_rsp_data(mem_rsp_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data),
    .out_last(out_last),
    .busy(busy)
  );
  pcl_mem_model mem (
    .clk(clk),
    .slow(slow),
    .mem_req_valid(mem_req_valid),
    .mem_req_ready(mem_req_ready),
    .mem_req_line(mem_req_line),
    .mem_rsp_valid(mem_rsp_valid),
    .mem_rsp_data(mem_rsp_data)
  );
  // Counts the aligned line requests that memory accepts.
  always @(posedge clk) begin
    if (mem_req_valid === 1'b1 && mem_req_ready === 1'b1) lines++;
  end
  initial forever #10 clk = ~clk;
  // Watchdog on the whole run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run;
    end
  end
  task automatic check(input string what, input logic [255:0] exp, got);
    comparisons++;
    if (exp !== got) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Compares one flag output.
  task automatic check_flag(input string what, input logic exp, got);
    comparisons++;
    if (exp !== got) begin
      mismatches++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Compares a count of events.
  task automatic check_count(input string what, input int exp, got);
    comparisons++;
    if (exp != got) begin
      mismatches++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // Load one buffer and take its halves, stalling every beat, odd beats one cycle longer.
  task automatic run_load(input logic [1:0] s, input logic [25:0] a,
      input logic [5:0] n, input int nl);
    @(posedge clk);
    lines = 0;
    cmd <= '{s, a, n};
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (int i = 0; i < n; i++) begin
      do @(negedge clk); while (out_valid !== 1'b1);
      check("half", mem.hv(26'(a + i)), out_data);
      check_flag("last", i == n - 1, out_last);
      if (i[0]) @(posedge clk);
      @(posedge clk);
      out_ready <= 1'b1;
      @(posedge clk);
      out_ready <= 1'b0;
    end
    @(negedge clk);
    check_flag("idle", 1'b1, cmd_ready);
    check_count("lines", nl, lines);
    $display("load of %0d halves at %h done", n, a);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence of loads over every gap case.
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    run_load(2'h1, 26'h0000105, 6'h04, 3);
    run_load(2'h2, 26'h0000203, 6'h05, 3);
    slow <= 1'b1;
    run_load(2'h3, 26'h0000300, 6'h03, 2);
    slow <= 1'b0;
    run_load(2'h0, 26'h0000040, 6'h02, 1);
    run_load(2'h0, 26'h0000001, 6'h3f, 32);
    @(posedge clk);
    lines = 0;
    cmd <= '{2'h1, 26'h0000007, 6'h00};
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
    check_flag("busy", 1'b0, busy);
    check_count("lines", 0, lines);
    $display("empty load done");
    complete_run;
  end
endmodule
